// file: dv/selwk_node_model.sv
// Behavioural CAN node that delivers wake-up frames and bus error events.
`timescale 1ns/1ns
module selwk_node_model (
    core_clk,
    frame_valid,
    frame_in,
    frame_error
);
    input  wire logic               core_clk;
    output logic                    frame_valid;
    output selwk_pkg::selwk_frame_t frame_in;
    output logic                    frame_error;

    initial begin
        frame_valid = 1'b0;
        frame_in    = '1;
        frame_error = 1'b0;
    end

    // Between frames the fields are inverted, so a stale frame can never look valid.
    task automatic send(input selwk_pkg::selwk_frame_t f);
        @(posedge core_clk);
        frame_valid <= 1'b1;
        frame_in    <= f;
        @(posedge core_clk);
        frame_valid <= 1'b0;
        frame_in    <= ~f;
    endtask

    task automatic bus_error();
        @(posedge core_clk);
        frame_error <= 1'b1;
        @(posedge core_clk);
        frame_error <= 1'b0;
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the selective-wake frame configuration block.
`timescale 1ns/1ns
module testbench;
    logic core_clk, rst, soft_reset, restart, reg_wr_en, reg_rd_en, silence_timeout;
    logic wake_receiver_select, frame_valid, frame_error, match_valid, match_hit;
    logic error_counter_active, use_standard_receiver;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, error_count;
    logic [4:0] ref_id_low;
    logic [9:0] fd_dominant_filter_time_ns;
    selwk_pkg::selwk_frame_t  frame_in;
    selwk_pkg::selwk_fd_cfg_t fd_cfg;
    int err_total = 0;
    int checks_done = 0;
    localparam logic [63:0] FULL = 64'h1716_1514_1312_1110;

    selwk_frame_config DUT (.core_clk, .rst, .soft_reset, .restart, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata, .reg_rdata, .silence_timeout, .wake_receiver_select, .ref_id_low,
        .frame_valid, .frame_in, .frame_error, .match_valid, .match_hit, .error_count,
        .error_counter_active, .use_standard_receiver, .fd_cfg, .fd_dominant_filter_time_ns);
    selwk_node_model node (.core_clk, .frame_valid, .frame_in, .frame_error);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input logic [1:0] sel);
        @(posedge core_clk);
        case (sel)
            2'h0: silence_timeout <= 1'b1;
            2'h1: restart <= 1'b1;
            default: soft_reset <= 1'b1;
        endcase
        @(posedge core_clk);
        {silence_timeout, restart, soft_reset} <= 3'h0;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1;
        chk({2'h0, reg_rdata}, {2'h0, exp});
    endtask

    task automatic frame(input logic [3:0] c, input logic [4:0] id, input logic [63:0] d, input logic hit);
        selwk_pkg::selwk_frame_t f;
        f.dlc    = c;
        f.id_low = id;
        f.data   = d;
        node.send(f);
        #1;
        chk({9'h0, match_valid}, 10'h001);
        chk({9'h0, match_hit}, {9'h0, hit});
    endtask

    task automatic t_reset();
        for (int k = 0; k < 8; k++) rd(selwk_pkg::ADDR_PAYLOAD[k], 8'h00);
        rd(selwk_pkg::ADDR_ID_MASK_LOW, 8'h00);
        rd(selwk_pkg::ADDR_LENGTH_CODE, 8'h00);
        rd(selwk_pkg::ADDR_FD_CONTROL, 8'h00);
        chk(fd_dominant_filter_time_ns, 10'h032);
        chk({9'h0, error_counter_active}, 10'h001);
        $display("test reset done");
    endtask

    task automatic t_regs();
        for (int k = 0; k < 8; k++) wr(selwk_pkg::ADDR_PAYLOAD[k], 8'h10 + 8'(k));
        for (int k = 0; k < 8; k++) rd(selwk_pkg::ADDR_PAYLOAD[k], 8'h10 + 8'(k));
        wr(selwk_pkg::ADDR_ID_MASK_LOW, 8'hff);
        rd(selwk_pkg::ADDR_ID_MASK_LOW, 8'h7c);
        wr(selwk_pkg::ADDR_LENGTH_CODE, 8'hff);
        rd(selwk_pkg::ADDR_LENGTH_CODE, 8'h0f);
        wr(7'h35, 8'h5a);
        rd(7'h35, 8'h00);
        $display("test registers done");
    endtask

    task automatic t_fd();
        logic [9:0] e;
        // The standard receiver is chosen before tolerant mode is switched on.
        @(posedge core_clk);
        wake_receiver_select <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            e = (c < 6) ? 10'h032 * 10'(c + 1) : ((c == 6) ? 10'h12c : 10'h2bc);
            wr(selwk_pkg::ADDR_FD_CONTROL, {4'h0, 3'(c), 1'b0});
            @(posedge core_clk);
            #1;
            chk(fd_dominant_filter_time_ns, e);
        end
        chk({9'h0, use_standard_receiver}, 10'h001);
        wr(selwk_pkg::ADDR_FD_CONTROL, 8'hff);
        rd(selwk_pkg::ADDR_FD_CONTROL, 8'h3f);
        chk({4'h0, fd_cfg}, 10'h03f);
        chk(fd_dominant_filter_time_ns, 10'h2bc);
        chk({9'h0, error_counter_active}, 10'h000);
        wr(selwk_pkg::ADDR_FD_CONTROL, 8'h20);
        rd(selwk_pkg::ADDR_FD_CONTROL, 8'h20);
        chk({8'h0, fd_cfg.analog_bypass, fd_cfg.fd_enable}, 10'h000);
        chk({9'h0, error_counter_active}, 10'h001);
        $display("test fd control done");
    endtask

    task automatic t_match();
        @(posedge core_clk);
        ref_id_low <= 5'h0a;
        wr(selwk_pkg::ADDR_ID_MASK_LOW, 8'h7c);
        wr(selwk_pkg::ADDR_LENGTH_CODE, 8'h03);
        frame(4'h3, 5'h0a, 64'hffff_ffff_ff12_1110, 1'b1);
        frame(4'h3, 5'h0a, 64'h0000_0000_0013_1110, 1'b0);
        frame(4'h3, 5'h0a, 64'h0000_0000_0012_11ff, 1'b0);
        frame(4'h3, 5'h0b, FULL, 1'b0);
        wr(selwk_pkg::ADDR_ID_MASK_LOW, 8'h78);
        frame(4'h3, 5'h0b, FULL, 1'b1);
        wr(selwk_pkg::ADDR_LENGTH_CODE, 8'h08);
        frame(4'h8, 5'h0a, FULL, 1'b1);
        frame(4'h9, 5'h0a, FULL, 1'b0);
        frame(4'h8, 5'h0a, FULL ^ 64'h8000_0000_0000_0000, 1'b0);
        wr(selwk_pkg::ADDR_LENGTH_CODE, 8'h0c);
        frame(4'hc, 5'h0a, FULL, 1'b1);
        frame(4'h8, 5'h0a, FULL, 1'b0);
        wr(selwk_pkg::ADDR_LENGTH_CODE, 8'h00);
        frame(4'h0, 5'h0a, 64'h0, 1'b1);
        wr(selwk_pkg::ADDR_LENGTH_CODE, 8'h0c);
        $display("test frame match done");
    endtask

    task automatic t_err();
        wr(selwk_pkg::ADDR_FD_CONTROL, 8'h00);
        repeat (3) node.bus_error();
        #1;
        chk({2'h0, error_count}, 10'h003);
        wr(selwk_pkg::ADDR_FD_CONTROL, 8'h21);
        node.bus_error();
        #1;
        chk({2'h0, error_count}, 10'h003);
        pulse(2'h0);
        rd(selwk_pkg::ADDR_FD_CONTROL, 8'h01);
        node.bus_error();
        #1;
        chk({2'h0, error_count}, 10'h004);
        $display("test error counter done");
    endtask

    task automatic t_restart();
        pulse(2'h1);
        rd(selwk_pkg::ADDR_ID_MASK_LOW, 8'h78);
        rd(selwk_pkg::ADDR_LENGTH_CODE, 8'h0c);
        rd(selwk_pkg::ADDR_PAYLOAD[7], 8'h17);
        pulse(2'h2);
        #1;
        chk({2'h0, error_count}, 10'h000);
        chk({9'h0, use_standard_receiver}, 10'h001);
        @(posedge core_clk);
        wake_receiver_select <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({9'h0, use_standard_receiver}, 10'h000);
        t_reset();
        $display("test restart done");
    endtask

    initial begin
        {rst, soft_reset, restart, reg_wr_en, reg_rd_en, silence_timeout} = 6'h20;
        {wake_receiver_select, reg_addr, reg_wdata, ref_id_low} = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_fd();
        t_match();
        t_err();
        t_restart();
        complete_run();
    end

    initial begin
        #500000;
        err_total++;
        complete_run();
    end
endmodule

// file: pkg/selwk_pkg.sv
// Constants and carrier types for the selective-wake frame configuration block.
package selwk_pkg;

    localparam int          ADDR_W            = 7;
    localparam int          DATA_W            = 8;
    localparam int          NUM_BYTES         = 8;

    localparam logic [6:0]  ADDR_ID_MASK_LOW  = 7'h2a;
    localparam logic [6:0]  ADDR_LENGTH_CODE  = 7'h2b;
    localparam logic [6:0]  ADDR_FD_CONTROL   = 7'h34;
    // Entry k is the address of wake_payload_byte k.
    localparam logic [7:0][6:0] ADDR_PAYLOAD  = {7'h2c, 7'h2d, 7'h2e, 7'h2f,
                                                 7'h30, 7'h31, 7'h32, 7'h33};

    localparam int          MASK_LSB          = 2;
    localparam int          MASK_MSB          = 6;
    localparam int          DLC_MSB           = 3;
    localparam int          FD_EN_BIT         = 0;
    localparam int          FILT_LSB          = 1;
    localparam int          FILT_MSB          = 3;
    localparam int          BYPASS_BIT        = 4;
    localparam int          ERR_DIS_BIT       = 5;

    localparam logic [7:0]  RESET_VALUE       = 8'h00;
    localparam logic [4:0]  MASK_RESET        = 5'h00;
    localparam logic [3:0]  DLC_RESET         = 4'h0;
    localparam logic [3:0]  DLC_FULL_LEN      = 4'h8;
    localparam logic [7:0]  ERR_COUNT_MAX     = 8'hff;

    localparam logic [9:0]  FILT_STEP_NS      = 10'h032;
    localparam logic [9:0]  FILT_LONGEST_NS   = 10'h2bc;
    localparam logic [2:0]  FILT_LAST_STEP    = 3'h5;
    localparam logic [2:0]  FILT_LONGEST_CODE = 3'h7;

    typedef struct packed {
        logic            err_cnt_disable;
        logic            analog_bypass;
        logic [2:0]      filter_code;
        logic            fd_enable;
    } selwk_fd_cfg_t;

    typedef struct packed {
        logic [3:0]      dlc;
        logic [4:0]      id_low;
        logic [7:0][7:0] data;
    } selwk_frame_t;

endpackage

// file: rtl/selwk_frame_config.sv
// Selective-wake frame configuration registers and wake-up frame comparator.
`timescale 1ns/1ns
// What this block does
// - Mask bits 6:2 select compared identifier bits.
// - Reserved register bits always read zero.
// - Length codes eight to fifteen mean eight.
// - Received length code must match exactly.
// - Eight independent eight-bit expected payload registers.
// - Bit 0 enables FD tolerant mode.
// - Bit 5 with FD mode suspends error counter.
// - Silence timeout clears error counter disable.
// - Bit 4 bypasses analog filter only.
// - Bits 3:1 pick dominant filter time.
// - Power-on and soft reset zero the fields; filter time resets to 50 ns, and only power-on clears receiver select.
// - Restart keeps fields, reserved bits zero.
// - Receiver select zero means low-power receiver.
module selwk_frame_config (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   soft_reset,
    input  wire logic                   restart,
    input  wire logic                   reg_wr_en,
    input  wire logic                   reg_rd_en,
    input  wire logic [6:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   silence_timeout,
    input  wire logic                   wake_receiver_select,
    input  wire logic [4:0]             ref_id_low,
    input  wire logic                   frame_valid,
    input  wire selwk_pkg::selwk_frame_t frame_in,
    input  wire logic                   frame_error,
    output logic                        match_valid,
    output logic                        match_hit,
    output logic [7:0]                  error_count,
    output logic                        error_counter_active,
    output logic                        use_standard_receiver,
    output selwk_pkg::selwk_fd_cfg_t    fd_cfg,
    output logic [9:0]                  fd_dominant_filter_time_ns
);

    logic [4:0]                id_low_compare_mask_reg;
    logic [3:0]                length_code_reg;
    logic [7:0]                payload_reg [8];
    selwk_pkg::selwk_fd_cfg_t  fd_cfg_reg;
    logic [7:0]                rdata_next;
    logic [7:0]                byte_hit;
    logic [3:0]                byte_count;
    logic                      id_hit;
    logic                      match_next;
    logic                      match_valid_reg;
    logic                      match_hit_reg;
    logic [7:0]                error_count_reg;
    logic                      use_std_reg;
    logic [9:0]                filter_ns_reg;
    logic [9:0]                filter_ns_next;
    logic                      cfg_clear;

    // Soft reset acts as a power-on reset on every register of this block except the receiver select.
    assign cfg_clear = rst | soft_reset;

    // Restart is deliberately absent here: configured fields survive it.
    always_ff @(posedge core_clk) begin
        if (cfg_clear) begin
            id_low_compare_mask_reg <= selwk_pkg::MASK_RESET;
        end else if (reg_wr_en && reg_addr == selwk_pkg::ADDR_ID_MASK_LOW) begin
            id_low_compare_mask_reg <= reg_wdata[selwk_pkg::MASK_MSB:selwk_pkg::MASK_LSB];
        end
    end

    always_ff @(posedge core_clk) begin
        if (cfg_clear) begin
            length_code_reg <= selwk_pkg::DLC_RESET;
        end else if (reg_wr_en && reg_addr == selwk_pkg::ADDR_LENGTH_CODE) begin
            length_code_reg <= reg_wdata[selwk_pkg::DLC_MSB:0];
        end
    end

    genvar k;
    generate
        for (k = 0; k < selwk_pkg::NUM_BYTES; k++) begin : g_byte
            always_ff @(posedge core_clk) begin
                if (cfg_clear) begin
                    payload_reg[k] <= selwk_pkg::RESET_VALUE;
                end else if (reg_wr_en && reg_addr == selwk_pkg::ADDR_PAYLOAD[k]) begin
                    payload_reg[k] <= reg_wdata;
                end
            end

            // Bytes past the configured length always count as equal.
            assign byte_hit[k] = (4'(k) >= byte_count) || (frame_in.data[k] == payload_reg[k]);

            // Each byte register must take a write to its own address and no other.
            payload_lands_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
                reg_wr_en && reg_addr == selwk_pkg::ADDR_PAYLOAD[k]
                |=> payload_reg[k] == $past(reg_wdata))
                else $error("Payload byte write did not land.");

            payload_holds_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
                !(reg_wr_en && reg_addr == selwk_pkg::ADDR_PAYLOAD[k])
                |=> payload_reg[k] == $past(payload_reg[k]))
                else $error("Payload byte changed without its own write.");
        end
    endgenerate

    // A host write in the same cycle as the timeout wins, so software intent is never lost.
    always_ff @(posedge core_clk) begin
        if (cfg_clear) begin
            fd_cfg_reg <= '0;
        end else if (reg_wr_en && reg_addr == selwk_pkg::ADDR_FD_CONTROL) begin
            fd_cfg_reg.err_cnt_disable <= reg_wdata[selwk_pkg::ERR_DIS_BIT];
            fd_cfg_reg.analog_bypass   <= reg_wdata[selwk_pkg::BYPASS_BIT];
            fd_cfg_reg.filter_code     <= reg_wdata[selwk_pkg::FILT_MSB:selwk_pkg::FILT_LSB];
            fd_cfg_reg.fd_enable       <= reg_wdata[selwk_pkg::FD_EN_BIT];
        end else if (silence_timeout) begin
            fd_cfg_reg.err_cnt_disable <= 1'b0;
        end
    end

    // Codes 8 to 15 all mean a full payload.
    always_comb begin
        if (length_code_reg >= selwk_pkg::DLC_FULL_LEN) begin
            byte_count = selwk_pkg::DLC_FULL_LEN;
        end else begin
            byte_count = length_code_reg;
        end
    end

    assign id_hit     = ((frame_in.id_low ^ ref_id_low) & id_low_compare_mask_reg) == 5'h00;
    assign match_next = (frame_in.dlc == length_code_reg) && id_hit && (&byte_hit);

    always_ff @(posedge core_clk) begin
        if (cfg_clear) begin
            match_valid_reg <= 1'b0;
            match_hit_reg   <= 1'b0;
        end else begin
            match_valid_reg <= frame_valid;
            match_hit_reg   <= frame_valid && match_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (cfg_clear) begin
            error_count_reg <= selwk_pkg::RESET_VALUE;
        end else if (frame_error && error_counter_active && error_count_reg != selwk_pkg::ERR_COUNT_MAX) begin
            error_count_reg <= error_count_reg + 8'h01;
        end
    end

    assign error_counter_active = !(fd_cfg_reg.err_cnt_disable && fd_cfg_reg.fd_enable);

    // Sampled register so the receiver choice cannot glitch mid-frame.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            use_std_reg <= 1'b0;
        end else begin
            use_std_reg <= wake_receiver_select;
        end
    end

    // Filter times run from 50 to 700 ns, half a core cycle up to seven, so they leave as nanoseconds.
    always_comb begin
        if (fd_cfg_reg.filter_code == selwk_pkg::FILT_LONGEST_CODE) begin
            filter_ns_next = selwk_pkg::FILT_LONGEST_NS;
        end else if (fd_cfg_reg.filter_code > selwk_pkg::FILT_LAST_STEP) begin
            filter_ns_next = 10'(selwk_pkg::FILT_STEP_NS * ({7'h00, selwk_pkg::FILT_LAST_STEP} + 10'h001));
        end else begin
            filter_ns_next = 10'(selwk_pkg::FILT_STEP_NS * ({7'h00, fd_cfg_reg.filter_code} + 10'h001));
        end
    end

    always_ff @(posedge core_clk) begin
        if (cfg_clear) begin
            filter_ns_reg <= selwk_pkg::FILT_STEP_NS;
        end else begin
            filter_ns_reg <= filter_ns_next;
        end
    end

    // Reserved bits are built as constant zero, so a restart cannot disturb them.
    always_comb begin
        rdata_next = selwk_pkg::RESET_VALUE;
        case (reg_addr)
            selwk_pkg::ADDR_ID_MASK_LOW: begin
                rdata_next = {1'b0, id_low_compare_mask_reg, 2'b00};
            end
            selwk_pkg::ADDR_LENGTH_CODE: begin
                rdata_next = {4'h0, length_code_reg};
            end
            selwk_pkg::ADDR_FD_CONTROL: begin
                rdata_next = {2'b00, fd_cfg_reg};
            end
            default: begin
                for (int i = 0; i < selwk_pkg::NUM_BYTES; i++) begin
                    if (reg_addr == selwk_pkg::ADDR_PAYLOAD[i]) begin
                        rdata_next = payload_reg[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (cfg_clear) begin
            reg_rdata <= selwk_pkg::RESET_VALUE;
        end else if (reg_rd_en) begin
            reg_rdata <= rdata_next;
        end
    end

    assign match_valid                = match_valid_reg;
    assign match_hit                  = match_hit_reg;
    assign error_count                = error_count_reg;
    assign use_standard_receiver      = use_std_reg;
    assign fd_cfg                     = fd_cfg_reg;
    assign fd_dominant_filter_time_ns = filter_ns_reg;

    // Checks beside the logic that they guard.
    mask_write_lands_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        reg_wr_en && reg_addr == selwk_pkg::ADDR_ID_MASK_LOW
        |=> id_low_compare_mask_reg == $past(reg_wdata[6:2]))
        else $error("Mask write did not land in bits 6:2.");

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(reg_rd_en) && ($past(reg_addr) == selwk_pkg::ADDR_ID_MASK_LOW)
        |-> reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'b00)
        else $error("Reserved mask bits read nonzero.");

    length_exact_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        frame_valid && frame_in.dlc != length_code_reg |=> !match_hit)
        else $error("Frame with wrong length code matched.");

    fd_enable_write_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        reg_wr_en && reg_addr == selwk_pkg::ADDR_FD_CONTROL
        |=> fd_cfg.fd_enable == $past(reg_wdata[0]) && fd_cfg.analog_bypass == $past(reg_wdata[4]))
        else $error("FD control write did not take effect.");

    error_suspend_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        !error_counter_active |=> error_count == $past(error_count))
        else $error("Error counter moved while suspended.");

    silence_clear_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        silence_timeout && !(reg_wr_en && reg_addr == selwk_pkg::ADDR_FD_CONTROL)
        |=> !fd_cfg.err_cnt_disable)
        else $error("Silence timeout did not clear the disable bit.");

    filter_time_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        fd_cfg.filter_code == 3'h2 [*2] |-> fd_dominant_filter_time_ns == 10'h096)
        else $error("Filter time for code 2 is not 150 ns.");

    soft_reset_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        soft_reset |=> length_code_reg == 4'h0 && fd_cfg == '0 && payload_reg[0] == 8'h00)
        else $error("Soft reset left a register nonzero.");

    restart_keeps_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        restart && !reg_wr_en |=> length_code_reg == $past(length_code_reg))
        else $error("Restart disturbed a configured field.");

    receiver_select_a: assert property (@(posedge core_clk) disable iff (rst)
        !wake_receiver_select |=> !use_standard_receiver)
        else $error("Standard receiver chosen with select low.");

    receiver_standard_a: assert property (@(posedge core_clk) disable iff (rst)
        wake_receiver_select |=> use_standard_receiver)
        else $error("Low-power receiver kept with select high.");

    length_write_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        reg_wr_en && reg_addr == selwk_pkg::ADDR_LENGTH_CODE
        |=> length_code_reg == $past(reg_wdata[3:0]))
        else $error("Length code write did not land in bits 3:0.");

    // Readback of the reserved positions is checked on the cycle after each read.
    reserved_upper_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(reg_rd_en) && ($past(reg_addr) == selwk_pkg::ADDR_LENGTH_CODE)
        |-> reg_rdata[7:4] == 4'h0)
        else $error("Reserved length bits read nonzero.");

    reserved_fd_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(reg_rd_en) && ($past(reg_addr) == selwk_pkg::ADDR_FD_CONTROL)
        |-> reg_rdata[7:6] == 2'b00)
        else $error("Reserved FD control bits read nonzero.");

    // A frame that differs in a compared identifier bit must never wake the node.
    id_mismatch_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        frame_valid && (|(id_low_compare_mask_reg & (frame_in.id_low ^ ref_id_low)))
        |=> !match_hit)
        else $error("Frame with a masked identifier mismatch matched.");

    // Byte 0 lies inside every length from one upwards, so it is always compared there.
    byte0_compared_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        frame_valid && length_code_reg != 4'h0 && frame_in.data[0] != payload_reg[0]
        |=> !match_hit)
        else $error("Frame with a wrong first byte matched.");

    full_length_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        frame_valid && length_code_reg[3] && frame_in.data[7] != payload_reg[7]
        |=> !match_hit)
        else $error("Last byte ignored for a length code of eight or more.");

    zero_length_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        frame_valid && length_code_reg == 4'h0 && frame_in.dlc == 4'h0
        && !(|(id_low_compare_mask_reg & (frame_in.id_low ^ ref_id_low)))
        |=> match_hit)
        else $error("Zero-length frame with a matching identifier missed.");

    // The second counter check reads the FD enable bit directly, not the combined gate.
    counter_idle_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        !frame_error |=> error_count == $past(error_count))
        else $error("Error counter moved without an error event.");

    disable_needs_fd_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        frame_error && !fd_cfg.fd_enable && error_count != 8'hff
        |=> error_count == $past(error_count) + 8'h01)
        else $error("Error counter stopped with FD tolerant mode off.");

    bypass_filter_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        (fd_cfg.analog_bypass && fd_cfg.filter_code == 3'h7) [*2] |-> fd_dominant_filter_time_ns == 10'h2bc)
        else $error("Analog bypass disturbed the dominant filter time.");

    // Restart must leave every configured field as the host last wrote it.
    restart_fields_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        restart && !reg_wr_en && !silence_timeout
        |=> id_low_compare_mask_reg == $past(id_low_compare_mask_reg) && fd_cfg == $past(fd_cfg))
        else $error("Restart disturbed the mask or FD control fields.");

    match_pairs_a: assert property (@(posedge core_clk) disable iff (cfg_clear)
        match_hit |-> match_valid)
        else $error("Match reported without a frame.");

    cover_match_c: cover property (@(posedge core_clk) disable iff (cfg_clear)
        frame_valid ##1 match_hit);

    cover_full_len_c: cover property (@(posedge core_clk) disable iff (cfg_clear)
        frame_valid && length_code_reg > 4'h8 ##1 match_hit);

    cover_timeout_c: cover property (@(posedge core_clk) disable iff (cfg_clear)
        fd_cfg.err_cnt_disable ##1 silence_timeout ##1 !fd_cfg.err_cnt_disable);

    cover_restart_c: cover property (@(posedge core_clk) disable iff (cfg_clear)
        restart ##1 length_code_reg != 4'h0);

    cover_suspend_c: cover property (@(posedge core_clk) disable iff (cfg_clear)
        frame_error && !error_counter_active);

endmodule
